/* File: hdl/bcb_pkg.sv */
// constants, field layout and mode type of the brushless commutation block
// assumes one 200 MHz clock and synchronous pin inputs
package bcb_pkg;
   // register byte addresses on the apb bus
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CMD = 8'h04;
   localparam logic [7:0] ADDR_BRAKE = 8'h08;
   localparam logic [7:0] ADDR_PERIOD = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_MASK = 8'h14;
   localparam logic [7:0] ADDR_STATE = 8'h18;
   // control register fields
   localparam int CTRL_REV_BIT = 0;
   localparam int CTRL_H60_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   // status and mask fields
   localparam int ST_CLIM = 0;
   localparam int ST_HALL = 1;
   localparam int ST_OTP = 2;
   localparam int ST_LOCK = 3;
   localparam int ST_LVS = 4;
   localparam int ST_W = 5;
   localparam logic [ST_W-1:0] MASK_RESET = 5'h00;
   // state register field positions
   localparam int STATE_MODE_LSB = 4;
   localparam int STATE_GATE_LSB = 8;
   localparam int STATE_PWM_BIT = 14;
   localparam int STATE_DUTY_LSB = 16;
   // current sense scale, one code per millivolt
   localparam int SENSE_MV_PER_LSB = 1;
   localparam int CLIMIT_MV = 100;
   localparam logic [9:0] CLIMIT_CODE = 10'(CLIMIT_MV / SENSE_MV_PER_LSB);
   localparam logic [9:0] CMD_RESET = 10'h000;
   // brake setting, a lower value allows a larger brake duty
   localparam logic [9:0] BRAKE_FULL = 10'h3FF;
   localparam logic [9:0] BRAKE_RESET = 10'h200;
   // sawtooth period, default 20 kHz
   localparam int SYS_CLK_KHZ = 200000;
   localparam int PWM_FREQ_KHZ = 20;
   localparam logic [15:0] PERIOD_RESET = 16'(SYS_CLK_KHZ / PWM_FREQ_KHZ);
   localparam logic [15:0] PERIOD_MIN = 16'h0002;
   // drive modes
   typedef enum logic [3:0] {
      BCB_DRIVE = 4'b0001,
      BCB_SHORT = 4'b0010,
      BCB_REGEN = 4'b0100,
      BCB_OFF = 4'b1000
   } bcb_mode_t;
endpackage

/* File: hdl/bcb_pwm_if.sv */
// link between the control top and the pwm generator
// assumes both ends share sys_clk
`timescale 1ns/100ps
`default_nettype none
interface bcb_pwm_if;
   logic [15:0] period;
   logic [9:0] cmd;
   logic [9:0] brake_duty;
   logic [9:0] sense;
   logic regen;
   logic pwm_on;
   logic climit;
   logic [15:0] duty;
   logic [15:0] saw;
   modport ctl (output period, cmd, brake_duty, sense, regen,
                input pwm_on, climit, duty, saw);
   modport gen (input period, cmd, brake_duty, sense, regen,
                output pwm_on, climit, duty, saw);
endinterface
`default_nettype wire

/* File: hdl/bcb_hall_decode.sv */
// hall code to gate pair decoder, purely combinational
// assumes hall inputs already synchronous; bit order {a,b,c}
`timescale 1ns/100ps
`default_nettype none
module bcb_hall_decode (
   // position and options
   input wire logic [2:0] hall,
   input wire logic sel60,
   input wire logic reverse,
   // one-hot phase selects, bit0 = phase a
   output logic [2:0] hi,
   output logic [2:0] lo,
   output logic valid
);
   logic [2:0] code;
   logic [2:0] fh;
   logic [2:0] fl;

   // 60 degree sensors map onto the 120 code by flipping sensor b
   always_comb begin
      code = sel60 ? {hall[2], ~hall[1], hall[0]} : hall;
      fh = 3'h0;
      fl = 3'h0;
      valid = 1'b1;
      case (code)
         3'h5: begin fh = 3'h1; fl = 3'h2; end
         3'h4: begin fh = 3'h1; fl = 3'h4; end
         3'h6: begin fh = 3'h2; fl = 3'h4; end
         3'h2: begin fh = 3'h2; fl = 3'h1; end
         3'h3: begin fh = 3'h4; fl = 3'h1; end
         3'h1: begin fh = 3'h4; fl = 3'h2; end
         default: valid = 1'b0;
      endcase
      // raw all-high is invalid in both modes; costs one 60 degree sector
      if (hall == 3'h7) begin
         valid = 1'b0;
      end
      // reverse swaps source and sink phases of each sector
      hi = reverse ? fl : fh;
      lo = reverse ? fh : fl;
      if (!valid) begin
         hi = 3'h0;
         lo = 3'h0;
      end
   end
endmodule // bcb_hall_decode
`default_nettype wire

/* File: hdl/bcb_pwm.sv */
// sawtooth pwm with current loop, cycle limit and brake cap
// assumes sense codes in millivolts and a static period between writes
`timescale 1ns/100ps
`default_nettype none
module bcb_pwm
   import bcb_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // control side
   bcb_pwm_if.gen pif
);
   logic [15:0] saw_reg, saw_next, duty_reg, duty_next;
   logic cut_reg, cut_next, on_reg, on_next, clim_reg, clim_next;
   logic [15:0] top_cnt, cap, eff;
   logic over, wrap;

   // sawtooth, integrating current loop and cycle cut
   always_comb begin
      top_cnt = (pif.period < PERIOD_MIN) ? PERIOD_MIN - 16'h0001 :
                pif.period - 16'h0001;
      wrap = (saw_reg >= top_cnt);
      over = (pif.sense > CLIMIT_CODE);
      cap = {6'h00, BRAKE_FULL - pif.brake_duty};
      eff = (pif.regen && duty_reg > cap) ? cap : duty_reg;
      saw_next = wrap ? 16'h0000 : saw_reg + 16'h0001;
      duty_next = duty_reg;
      // one step per period keeps the loop slow and stable
      if (wrap) begin
         if (pif.sense < pif.cmd && duty_reg < top_cnt) begin
            duty_next = duty_reg + 16'h0001;
         end else if (pif.sense > pif.cmd && duty_reg != 16'h0000) begin
            duty_next = duty_reg - 16'h0001;
         end
      end
      cut_next = over | (cut_reg & ~wrap);
      on_next = (saw_next < eff) & ~cut_next;
      clim_next = over;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         saw_reg <= 16'h0000;
         duty_reg <= 16'h0000;
         cut_reg <= 1'b0;
         on_reg <= 1'b0;
         clim_reg <= 1'b0;
      end else begin
         saw_reg <= saw_next;
         duty_reg <= duty_next;
         cut_reg <= cut_next;
         on_reg <= on_next;
         clim_reg <= clim_next;
      end
   end

   assign pif.saw = saw_reg;
   assign pif.duty = duty_reg;
   assign pif.pwm_on = on_reg;
   assign pif.climit = clim_reg;

   a_climit_cut: assert property (@(posedge sys_clk) disable iff (rst)
      over |=> !on_reg ##1 (!on_reg || saw_reg == 16'h0000))
      else $error("pwm pulse not cut after current limit");
   a_climit_flag: assert property (@(posedge sys_clk) disable iff (rst)
      (pif.sense > 10'h064) |=> clim_reg)
      else $error("current limit not flagged");
   a_saw_wrap: assert property (@(posedge sys_clk) disable iff (rst)
      (saw_reg >= top_cnt && $stable(pif.period)) |=> saw_reg == 16'h0000)
      else $error("sawtooth did not wrap");
   a_duty_step: assert property (@(posedge sys_clk) disable iff (rst)
      !$stable(duty_reg) |-> $past(wrap))
      else $error("duty moved outside a period wrap");
   a_regen_cap: assert property (@(posedge sys_clk) disable iff (rst)
      ($past(pif.regen) && on_reg) |->
      saw_reg < {6'h00, BRAKE_FULL - $past(pif.brake_duty)})
      else $error("regen pulse exceeds brake cap");
endmodule // bcb_pwm
`default_nettype wire

/* File: hdl/bcb_top.sv */
// commutation, braking and protection top with apb registers
// assumes all pin inputs synchronous to sys_clk; sense is a millivolt code
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module bcb_top
   import bcb_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // apb slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // position and control pins
   input wire logic hall_in_a,
   input wire logic hall_in_b,
   input wire logic hall_in_c,
   input wire logic short_brake_request,
   input wire logic regen_brake_n,
   input wire logic [9:0] current_sense_in,
   // protection inputs
   input wire logic over_temp_in,
   input wire logic locked_rotor_protect,
   input wire logic low_supply_shutdown,
   // gate drives
   output logic high_gate_a,
   output logic high_gate_b,
   output logic high_gate_c,
   output logic low_gate_a,
   output logic low_gate_b,
   output logic low_gate_c,
   // interrupt
   output logic irq
);
   bcb_pwm_if pif ();

   logic [1:0] ctrl_reg, ctrl_next;
   logic [9:0] cmd_reg, cmd_next, brake_reg, brake_next;
   logic [15:0] period_reg, period_next;
   logic [ST_W-1:0] status_reg, status_next, mask_reg, mask_next, ev;
   logic [31:0] prdata_reg, prdata_next, rdata;
   logic pready_reg, pready_next, pslverr_reg, pslverr_next;
   logic irq_reg, irq_next;
   bcb_mode_t mode_reg, mode_next;
   logic [2:0] hi_reg, hi_next, lo_reg, lo_next;
   logic [2:0] dec_hi, dec_lo, hall;
   logic dec_valid, fault, done, wr, rd_status, hit;

   assign hall = {hall_in_a, hall_in_b, hall_in_c};
   assign fault = over_temp_in | locked_rotor_protect | low_supply_shutdown;

   bcb_hall_decode u_dec (
      .hall(hall),
      .sel60(ctrl_reg[CTRL_H60_BIT]),
      .reverse(ctrl_reg[CTRL_REV_BIT]),
      .hi(dec_hi),
      .lo(dec_lo),
      .valid(dec_valid)
   );

   bcb_pwm u_pwm (
      .sys_clk(sys_clk),
      .rst(rst),
      .pif(pif)
   );

   // loop settings and sense into the pwm generator
   assign pif.period = period_reg;
   assign pif.cmd = cmd_reg;
   assign pif.brake_duty = brake_reg;
   assign pif.sense = current_sense_in;
   assign pif.regen = (mode_reg == BCB_REGEN);

   // mode choice, protection first so a fault always wins
   always_comb begin
      if (fault) begin
         mode_next = BCB_OFF;
      end else if (short_brake_request) begin
         mode_next = BCB_SHORT;
      end else if (!dec_valid) begin
         mode_next = BCB_OFF;
      end else if (!regen_brake_n) begin
         mode_next = BCB_REGEN;
      end else begin
         mode_next = BCB_DRIVE;
      end
   end

   // gate pattern per mode; the pwm chops only the high side
   always_comb begin
      case (mode_next)
         BCB_DRIVE, BCB_REGEN: begin
            hi_next = dec_hi & {3{pif.pwm_on}};
            lo_next = dec_lo;
         end
         BCB_SHORT: begin
            hi_next = 3'h0;
            lo_next = 3'h7;
         end
         BCB_OFF: begin
            hi_next = 3'h0;
            lo_next = 3'h0;
         end
         default: begin
            hi_next = 3'h0;
            lo_next = 3'h0;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mode_reg <= BCB_OFF;
         hi_reg <= 3'h0;
         lo_reg <= 3'h0;
      end else begin
         mode_reg <= mode_next;
         hi_reg <= hi_next;
         lo_reg <= lo_next;
      end
   end

   assign high_gate_a = hi_reg[0];
   assign high_gate_b = hi_reg[1];
   assign high_gate_c = hi_reg[2];
   assign low_gate_a = lo_reg[0];
   assign low_gate_b = lo_reg[1];
   assign low_gate_c = lo_reg[2];

   // read mux, unmapped addresses read zero
   always_comb begin
      rdata = 32'h0000_0000;
      hit = 1'b1;
      case (paddr)
         ADDR_CTRL: rdata[1:0] = ctrl_reg;
         ADDR_CMD: rdata[9:0] = cmd_reg;
         ADDR_BRAKE: rdata[9:0] = brake_reg;
         ADDR_PERIOD: rdata[15:0] = period_reg;
         ADDR_STATUS: rdata[ST_W-1:0] = status_reg;
         ADDR_MASK: rdata[ST_W-1:0] = mask_reg;
         ADDR_STATE: begin
            rdata[2:0] = hall;
            rdata[STATE_MODE_LSB +: 4] = mode_reg;
            rdata[STATE_GATE_LSB +: 6] = {lo_reg, hi_reg};
            rdata[STATE_PWM_BIT] = pif.pwm_on;
            rdata[STATE_DUTY_LSB +: 16] = pif.duty;
         end
         default: hit = 1'b0;
      endcase
   end

   // apb: one wait state, data and error registered with pready
   always_comb begin
      done = psel & penable & pready_reg;
      wr = done & pwrite & ~pslverr_reg;
      rd_status = done & ~pwrite & (paddr == ADDR_STATUS);
      pready_next = psel & penable & ~pready_reg;
      prdata_next = prdata_reg;
      pslverr_next = 1'b0;
      if (pready_next) begin
         prdata_next = pwrite ? 32'h0000_0000 : rdata;
         pslverr_next = ~hit;
      end
      ctrl_next = ctrl_reg;
      cmd_next = cmd_reg;
      brake_next = brake_reg;
      period_next = period_reg;
      mask_next = mask_reg;
      if (wr) begin
         case (paddr)
            ADDR_CTRL: ctrl_next = pwdata[1:0];
            ADDR_CMD: cmd_next = pwdata[9:0];
            ADDR_BRAKE: brake_next = pwdata[9:0];
            ADDR_PERIOD: period_next = pwdata[15:0];
            ADDR_MASK: mask_next = pwdata[ST_W-1:0];
            default: ctrl_next = ctrl_reg;
         endcase
      end
   end

   // sticky events; only bits returned by the read are cleared, set wins
   always_comb begin
      ev = 5'h00;
      ev[ST_CLIM] = pif.climit;
      ev[ST_HALL] = (hall == 3'h7);
      ev[ST_OTP] = over_temp_in;
      ev[ST_LOCK] = locked_rotor_protect;
      ev[ST_LVS] = low_supply_shutdown;
      status_next = status_reg;
      if (rd_status) begin
         status_next = status_reg & ~prdata_reg[ST_W-1:0];
      end
      status_next = status_next | ev;
      irq_next = |(status_next & mask_next);
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= CTRL_RESET;
         cmd_reg <= CMD_RESET;
         brake_reg <= BRAKE_RESET;
         period_reg <= PERIOD_RESET;
         mask_reg <= MASK_RESET;
         status_reg <= 5'h00;
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         cmd_reg <= cmd_next;
         brake_reg <= brake_next;
         period_reg <= period_next;
         mask_reg <= mask_next;
         status_reg <= status_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         irq_reg <= irq_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq = irq_reg;

   a_short_entry: assert property (@(posedge sys_clk) disable iff (rst)
      (short_brake_request && !fault) |=> mode_reg == BCB_SHORT)
      else $error("short brake request not honoured");
   a_short_gates: assert property (@(posedge sys_clk) disable iff (rst)
      (mode_reg == BCB_SHORT) |-> (lo_reg == 3'h7 && hi_reg == 3'h0))
      else $error("short brake gate pattern wrong");
   a_regen_entry: assert property (@(posedge sys_clk) disable iff (rst)
      (!regen_brake_n && !short_brake_request && dec_valid && !fault)
      |=> mode_reg == BCB_REGEN)
      else $error("regen brake not entered");
   a_drive_entry: assert property (@(posedge sys_clk) disable iff (rst)
      (regen_brake_n && !short_brake_request && dec_valid && !fault)
      |=> mode_reg == BCB_DRIVE)
      else $error("normal drive not entered");
   a_hall_off: assert property (@(posedge sys_clk) disable iff (rst)
      (hall == 3'h7 && !short_brake_request) |=>
      (hi_reg == 3'h0 && lo_reg == 3'h0) ##1 status_reg[ST_HALL])
      else $error("invalid hall code did not stop drive");
   a_fault_off: assert property (@(posedge sys_clk) disable iff (rst)
      fault |=> (hi_reg == 3'h0 && lo_reg == 3'h0 && mode_reg == BCB_OFF))
      else $error("protection did not stop drive");
   a_phase_safe: assert property (@(posedge sys_clk) disable iff (rst)
      (hi_reg & lo_reg) == 3'h0)
      else $error("both gates of one phase on");
   a_one_pair: assert property (@(posedge sys_clk) disable iff (rst)
      (mode_reg == BCB_DRIVE) |-> ($onehot(lo_reg) && $onehot0(hi_reg)))
      else $error("drive pair not one high and one low");
   a_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
      irq_reg == |(status_reg & mask_reg))
      else $error("interrupt level disagrees with status");
endmodule // bcb_top
`default_nettype wire

/* File: testbench/bcb_motor_model.sv */
// hall sensors and three-phase bridge seen from the gate pins
// assumes the bench sets hall code and sense level on sys_clk
`timescale 1ns/100ps
`default_nettype none
module bcb_motor_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // bench settings
   input wire logic [2:0] hall_code,
   input wire logic [9:0] sense_level,
   // gate drives, bit0 = phase a
   input wire logic [2:0] hi_g,
   input wire logic [2:0] lo_g,
   // sensor pins and sense code
   output logic hall_in_a,
   output logic hall_in_b,
   output logic hall_in_c,
   output logic [9:0] current_sense_in,
   output logic shoot_through
);
   // hall lines sit high on their pull-ups while in reset
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         {hall_in_a, hall_in_b, hall_in_c} <= 3'h7;
      end else begin
         {hall_in_a, hall_in_b, hall_in_c} <= hall_code;
      end
   end
   // winding current only reaches the sense resistor via a closed low leg
   assign current_sense_in = (lo_g != 3'h0) ? sense_level : 10'h000;
   // sticky: both fets of one leg on would short the supply
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         shoot_through <= 1'b0;
      end else if ((hi_g & lo_g) != 3'h0) begin
         shoot_through <= 1'b1;
      end
   end
endmodule // bcb_motor_model
`default_nettype wire

/* File: testbench/bcb_top_tb_top.sv */
// bench for the commutation top: registers, hall table, brakes, pwm
// assumes bcb_motor_model stands in for hall sensors and bridge
`timescale 1ns/100ps
`default_nettype none
module bcb_top_tb_top import bcb_pkg::*; ;
   logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic ha, hb, hc, sbrk, rbn, otp, lock, lvs, shoot, eb;
   logic [2:0] hi_g, lo_g, hcode;
   logic [9:0] sense, level;
   int errors, total_checks, c;
   bcb_top bcb_top_i (.sys_clk(sys_clk), .rst(rst), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .hall_in_a(ha), .hall_in_b(hb), .hall_in_c(hc),
      .short_brake_request(sbrk), .regen_brake_n(rbn),
      .current_sense_in(sense), .over_temp_in(otp),
      .locked_rotor_protect(lock), .low_supply_shutdown(lvs),
      .high_gate_a(hi_g[0]), .high_gate_b(hi_g[1]), .high_gate_c(hi_g[2]),
      .low_gate_a(lo_g[0]), .low_gate_b(lo_g[1]), .low_gate_c(lo_g[2]),
      .irq(irq));
   bcb_motor_model bcb_motor_model_i (.sys_clk(sys_clk), .rst(rst),
      .hall_code(hcode), .sense_level(level), .hi_g(hi_g), .lo_g(lo_g),
      .hall_in_a(ha), .hall_in_b(hb), .hall_in_c(hc),
      .current_sense_in(sense), .shoot_through(shoot));
   // 200 MHz system clock
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic finish_test();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   // one apb transfer; result lands in rdat and eb
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         errors++;
         $display("MISMATCH %0t apb timeout", $time);
         finish_test();
      end
      rdat = prdata;
      eb = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdat, exp, "read data");
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // cycles with a high gate on, over two periods of 8; two settle edges
   // first, since pwm_on and the gate register each add one cycle
   task automatic cnt_hi();
      c = 0;
      tick(2);
      repeat (16) begin
         @(posedge sys_clk);
         if (hi_g !== 3'h0) c++;
      end
   endtask
   // expected {lo, hi} one-hot pair for a hall code
   function automatic logic [5:0] pair(input logic [2:0] h, input logic rv);
      logic [5:0] p;
      case (h)
         3'h5: p = {3'h2, 3'h1};
         3'h4: p = {3'h4, 3'h1};
         3'h6: p = {3'h4, 3'h2};
         3'h2: p = {3'h1, 3'h2};
         3'h3: p = {3'h1, 3'h4};
         3'h1: p = {3'h2, 3'h4};
         default: p = 6'h00;
      endcase
      return rv ? {p[2:0], p[5:3]} : p;
   endfunction
   // the pwm chops the high gate, so wait out an off slot before comparing
   task automatic gates(input logic [5:0] exp);
      for (int i = 0; i < 8 && exp[2:0] != 3'h0 && hi_g === 3'h0; i++) begin
         @(posedge sys_clk);
      end
      chk({26'h0, lo_g, hi_g}, {26'h0, exp}, "gates");
   endtask
   task automatic t_regs();
      rd(ADDR_CTRL, 32'h0);
      rd(ADDR_CMD, 32'h0);
      rd(ADDR_BRAKE, 32'h200);
      rd(ADDR_PERIOD, 32'h2710);
      rd(ADDR_MASK, 32'h0);
      apb(1'b1, 8'h1C, 32'hFFFFFFFF);
      rd(8'h1C, 32'h0);
      chk({31'h0, eb}, 32'h1, "unmapped error");
   endtask
   // short sawtooth and full command; duty tops out at period minus one,
   // so 7 of every 8 cycles carry a pulse
   task automatic t_spin();
      apb(1'b1, ADDR_PERIOD, 32'h8);
      apb(1'b1, ADDR_CMD, 32'h3FF);
      for (int i = 0; i < 100 && c != 14; i++) cnt_hi();
      chk(c, 14, "top duty");
      apb(1'b0, ADDR_STATE, 32'h0);
      chk({28'h0, rdat[7:4]}, 32'h1, "drive mode");
   endtask
   task automatic t_hall();
      for (int rv = 0; rv < 2; rv++) begin
         apb(1'b1, ADDR_CTRL, 32'(rv));
         for (int h = 1; h < 7; h++) begin
            hcode <= 3'(h);
            tick(4);
            gates(pair(3'(h), rv[0]));
         end
      end
      for (int h = 0; h < 8; h++) begin
         apb(1'b1, ADDR_CTRL, 32'h2);
         hcode <= 3'(h);
         tick(4);
         gates(h == 7 ? 6'h00 : pair({h[2], ~h[1], h[0]}, 1'b0));
      end
      apb(1'b1, ADDR_CTRL, 32'h0);
      tick(4);
      gates(6'h00);
      rd(ADDR_STATUS, 32'h2);
      hcode <= 3'h5;
      tick(4);
   endtask
   task automatic t_short();
      sbrk <= 1'b1;
      rbn <= 1'b0;
      tick(4);
      gates(6'h38);
      apb(1'b0, ADDR_STATE, 32'h0);
      chk({28'h0, rdat[7:4]}, 32'h2, "short mode");
      hcode <= 3'h7;
      tick(4);
      gates(6'h38);
      sbrk <= 1'b0;
      rbn <= 1'b1;
      hcode <= 3'h5;
      tick(4);
      gates(pair(3'h5, 1'b0));
   endtask
   task automatic t_regen();
      rbn <= 1'b0;
      apb(1'b1, ADDR_BRAKE, 32'h3FF);
      cnt_hi();
      chk(c, 0, "regen cap zero");
      chk({29'h0, lo_g}, 32'h2, "regen low leg");
      apb(1'b0, ADDR_STATE, 32'h0);
      chk({28'h0, rdat[7:4]}, 32'h4, "regen mode");
      apb(1'b1, ADDR_BRAKE, 32'h3FB);
      cnt_hi();
      chk(c, 8, "regen half duty");
      rbn <= 1'b1;
      tick(2);
      cnt_hi();
      chk(c, 14, "regen released");
      apb(1'b1, ADDR_BRAKE, 32'h200);
   endtask
   task automatic t_climit();
      level <= 10'd100;
      apb(1'b0, ADDR_STATUS, 32'h0);
      cnt_hi();
      chk(c, 14, "at limit no cut");
      rd(ADDR_STATUS, 32'h0);
      level <= 10'd101;
      tick(4);
      cnt_hi();
      chk({31'h0, c < 8}, 32'h1, "cut per cycle");
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk({31'h0, rdat[ST_CLIM]}, 32'h1, "limit flag");
      level <= 10'd0;
      tick(20);
   endtask
   task automatic t_protect();
      apb(1'b1, ADDR_MASK, 32'h4);
      apb(1'b0, ADDR_STATUS, 32'h0);
      for (int i = 0; i < 3; i++) begin
         {lvs, lock, otp} <= 3'h1 << i;
         sbrk <= (i == 1);
         tick(4);
         gates(6'h00);
         apb(1'b0, ADDR_STATE, 32'h0);
         chk({28'h0, rdat[7:4]}, 32'h8, "fault off mode");
         chk({31'h0, irq}, 32'(i == 0), "masked irq");
         {lvs, lock, otp} <= 3'h0;
         sbrk <= 1'b0;
         tick(4);
         rd(ADDR_STATUS, 32'h4 << i);
         tick(4);
         chk({31'h0, irq}, 32'h0, "irq cleared");
      end
   endtask
   // sense above command walks the duty down to nothing
   task automatic t_down();
      apb(1'b1, ADDR_CMD, 32'h0);
      level <= 10'd5;
      c = 1;
      for (int i = 0; i < 400 && c != 0; i++) cnt_hi();
      chk(c, 0, "duty fell");
      chk({31'h0, shoot}, 32'h0, "leg shorted");
   endtask
   initial begin
      errors = 0;
      total_checks = 0;
      c = 0;
      rst = 1'b1;
      {psel, penable, pwrite, sbrk, otp, lock, lvs} = 7'h00;
      rbn = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0;
      hcode = 3'h5;
      level = 10'h000;
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      t_regs();
      t_spin();
      t_hall();
      t_short();
      t_regen();
      t_climit();
      t_protect();
      t_down();
      finish_test();
   end
endmodule // bcb_top_tb_top
`default_nettype wire
